// ===== shared/mscfg_defines.vh
// Functional notes
// RULE1: strap short/170k give first family, 270k/open second; 170k/open pick switch sensing.
// RULE2: board fixes strap and table select before start-up, never changes them.
// RULE3: first family applies the fixed negative set-point offset in both tables.
// RULE4: first family: table select open picks eight-bit table, ground the half-step table.
// RULE5: first family: open code input reads one via pull-up, grounded reads zero.
// RULE6: second family: open low-six inputs read zero via pull-down, driven high reads one.
// RULE7: second family: board ties code bit six and table select to signal ground.
// RULE8: second family: top code pin outputs transition flag, held 32 cycles after.
// RULE9: current code picks the reference tap; runtime changes become dynamic transitions.
// RULE10: first family: status output released once soft-start completes.
// RULE11: second family: status output released after soft-start while output in limits.
// RULE12: soft-start pin programs duration in first family, carries reference in second.
// RULE13: strap and table select sampled once after power-up, held until next power-up.
`ifndef MSCFG_DEFINES_VH
`define MSCFG_DEFINES_VH

// ------------------------------------------------------------
// strap levels from the strap comparator
// ------------------------------------------------------------
`define MSCFG_STRAP_SHORT     2'h0
`define MSCFG_STRAP_170K      2'h1
`define MSCFG_STRAP_270K      2'h2
`define MSCFG_STRAP_OPEN      2'h3

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define MSCFG_ADDR_CTRL       4'h0
`define MSCFG_ADDR_STATUS     4'h4
`define MSCFG_ADDR_IRQ_STAT   4'h8
`define MSCFG_ADDR_IRQ_MASK   4'hC

// ------------------------------------------------------------
// fields, resets and timing
// ------------------------------------------------------------
`define MSCFG_CTRL_RST        4'h0
`define MSCFG_IRQ_W           3
`define MSCFG_IRQ_RST         3'h0
`define MSCFG_IRQ_START       0
`define MSCFG_IRQ_END         1
`define MSCFG_IRQ_PLOSS       2
`define MSCFG_TAIL_CYCLES     6'h20
`define MSCFG_RESP_OKAY       2'h0
`define MSCFG_RESP_SLVERR     2'h2
`define MSCFG_LOW_SIX_PAD     2'h0

`endif

// ===== core/mscfg_top.v
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "mscfg_defines.vh"

module mscfg_top (
	input  wire        i_clk_sys,
	input  wire        i_srst,
	input  wire        i_ce,
	// board strap network and code pins
	input  wire [1:0]  i_strap_level,
	input  wire        i_code_table_select,
	input  wire [7:0]  i_voltage_code_level,
	input  wire [7:0]  i_voltage_code_driven,
	// analog loop status
	input  wire        i_softstart_done,
	input  wire        i_output_in_limits,
	// axi4-lite slave
	input  wire [3:0]  i_s_axi_awaddr,
	input  wire        i_s_axi_awvalid,
	output wire        o_s_axi_awready,
	input  wire [31:0] i_s_axi_wdata,
	input  wire [3:0]  i_s_axi_wstrb,
	input  wire        i_s_axi_wvalid,
	output wire        o_s_axi_wready,
	output reg  [1:0]  o_s_axi_bresp,
	output reg         o_s_axi_bvalid,
	input  wire        i_s_axi_bready,
	input  wire [3:0]  i_s_axi_araddr,
	input  wire        i_s_axi_arvalid,
	output wire        o_s_axi_arready,
	output reg  [31:0] o_s_axi_rdata,
	output reg  [1:0]  o_s_axi_rresp,
	output reg         o_s_axi_rvalid,
	input  wire        i_s_axi_rready,
	// configuration outputs
	output reg         o_config_valid,
	output reg         o_family_second,
	output reg         o_sense_switch,
	output reg         o_table_eight_bit,
	output reg         o_setpoint_offset_en,
	output reg         o_softstart_program_en,
	output reg         o_ref_out_en,
	output reg  [7:0]  o_ref_tap,
	// top code pin as transition flag output
	output reg         o_code_transition_flag,
	output reg         o_code_transition_flag_oe,
	// open-drain status pin, pulled low while enabled
	output wire        o_softstart_done_or_power_ok,
	output reg         o_softstart_done_or_power_ok_oe,
	output wire        o_irq
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg        aw_held_r;
	reg [3:0]  aw_addr_r;
	reg        w_held_r;
	reg [31:0] w_data_r;
	reg [3:0]  w_strb_r;
	reg [3:0]  step_div_r;
	reg [3:0]  step_cnt_r;
	reg [`MSCFG_IRQ_W-1:0] irq_stat_r;
	reg [`MSCFG_IRQ_W-1:0] irq_mask_r;
	reg        cfg_armed_r;
	reg [7:0]  target_r;
	reg [5:0]  tail_cnt_r;
	reg        moving_r;
	reg        power_ok_r;

	reg [7:0]  code_nxt;
	reg [`MSCFG_IRQ_W-1:0] irq_set_nxt;
	reg [31:0] rdata_nxt;
	reg [1:0]  rresp_nxt;

	wire       wr_fire;
	wire       rd_fire;
	wire       moving_now;
	wire       step_tick;
	wire       power_ok_now;
	wire [7:0] code_decoded;

	// ------------------------------------------------------------
	// code pin interpretation
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_pad
			// open pad reads one in first family, zero in second
			assign code_decoded[gi] = i_voltage_code_driven[gi] ? i_voltage_code_level[gi]
				: ~o_family_second; // RULE5 RULE6
		end
	endgenerate

	// code seen by the divider, bit six and top bit unused in second family
	always @* begin
		if (o_family_second) begin
			code_nxt = {`MSCFG_LOW_SIX_PAD, code_decoded[5:0]}; // RULE6 RULE7
		end else begin
			code_nxt = code_decoded; // RULE5
		end
	end

	// ------------------------------------------------------------
	// one-time configuration capture
	// ------------------------------------------------------------
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			cfg_armed_r            <= 1'b0;
			o_config_valid         <= 1'b0;
			o_family_second        <= 1'b0;
			o_sense_switch         <= 1'b0;
			o_table_eight_bit      <= 1'b0;
			o_setpoint_offset_en   <= 1'b0;
			o_softstart_program_en <= 1'b0;
			o_ref_out_en           <= 1'b0;
		end else if (i_ce) begin
			cfg_armed_r <= 1'b1;
			// capture once, one cycle after reset release
			if (cfg_armed_r && !o_config_valid) begin
				o_config_valid         <= 1'b1; // RULE13 RULE2
				o_family_second        <= (i_strap_level == `MSCFG_STRAP_270K) ||
					(i_strap_level == `MSCFG_STRAP_OPEN); // RULE1
				o_sense_switch         <= (i_strap_level == `MSCFG_STRAP_170K) ||
					(i_strap_level == `MSCFG_STRAP_OPEN); // RULE1
				o_table_eight_bit      <= i_code_table_select; // RULE4
				o_setpoint_offset_en   <= (i_strap_level == `MSCFG_STRAP_SHORT) ||
					(i_strap_level == `MSCFG_STRAP_170K); // RULE3
				o_softstart_program_en <= (i_strap_level == `MSCFG_STRAP_SHORT) ||
					(i_strap_level == `MSCFG_STRAP_170K); // RULE12
				o_ref_out_en           <= (i_strap_level == `MSCFG_STRAP_270K) ||
					(i_strap_level == `MSCFG_STRAP_OPEN); // RULE12
			end
		end
	end

	// ------------------------------------------------------------
	// reference tap and dynamic transitions
	// ------------------------------------------------------------
	assign moving_now = (o_ref_tap != target_r);
	assign step_tick  = (step_cnt_r == step_div_r);

	// tap walks one step per interval toward the sampled code
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			target_r   <= 8'h00;
			o_ref_tap  <= 8'h00;
			step_cnt_r <= 4'h0;
			moving_r   <= 1'b0;
			tail_cnt_r <= 6'h00;
		end else if (i_ce && o_config_valid) begin
			target_r <= code_nxt; // RULE9
			moving_r <= moving_now;
			// first code after capture walks from tap zero like any other change
			if (moving_now) begin
				step_cnt_r <= step_tick ? 4'h0 : step_cnt_r + 4'h1;
				if (step_tick) begin
					o_ref_tap <= (target_r > o_ref_tap) ? o_ref_tap + 8'h01
						: o_ref_tap - 8'h01; // RULE9
				end
			end else begin
				step_cnt_r <= 4'h0;
			end
			// flag tail after the tap settles
			if (moving_r && !moving_now) begin
				tail_cnt_r <= `MSCFG_TAIL_CYCLES; // RULE8
			end else if (tail_cnt_r != 6'h00) begin
				tail_cnt_r <= tail_cnt_r - 6'h01;
			end
		end
	end

	// top code pin driven only in second family; moving_r bridges the edge before the tail loads
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_code_transition_flag    <= 1'b0;
			o_code_transition_flag_oe <= 1'b0;
		end else if (i_ce) begin
			o_code_transition_flag_oe <= o_config_valid && o_family_second; // RULE8
			o_code_transition_flag    <= o_config_valid && o_family_second &&
				(moving_now || moving_r || tail_cnt_r != 6'h00); // RULE8
		end
	end

	// ------------------------------------------------------------
	// soft-start end or power-ok pin
	// ------------------------------------------------------------
	assign power_ok_now = o_family_second ? (i_softstart_done && i_output_in_limits) // RULE11
		: i_softstart_done; // RULE10
	assign o_softstart_done_or_power_ok = 1'b0;

	// pin held low until released
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			power_ok_r                      <= 1'b0;
			o_softstart_done_or_power_ok_oe <= 1'b1;
		end else if (i_ce) begin
			power_ok_r                      <= o_config_valid && power_ok_now;
			o_softstart_done_or_power_ok_oe <= !(o_config_valid && power_ok_now); // RULE10 RULE11
		end
	end

	// ------------------------------------------------------------
	// interrupt events
	// ------------------------------------------------------------
	always @* begin
		irq_set_nxt = `MSCFG_IRQ_RST;
		irq_set_nxt[`MSCFG_IRQ_START] = !moving_r && moving_now && o_config_valid;
		irq_set_nxt[`MSCFG_IRQ_END]   = o_family_second ? (tail_cnt_r == 6'h01) : (moving_r && !moving_now);
		irq_set_nxt[`MSCFG_IRQ_PLOSS] = power_ok_r && !power_ok_now;
	end

	assign o_irq = |(irq_stat_r & irq_mask_r);

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	assign o_s_axi_awready = !aw_held_r && !o_s_axi_bvalid;
	assign o_s_axi_wready  = !w_held_r && !o_s_axi_bvalid;
	assign wr_fire         = aw_held_r && w_held_r && !o_s_axi_bvalid;

	// address and data latched independently, applied together
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			aw_held_r      <= 1'b0;
			aw_addr_r      <= 4'h0;
			w_held_r       <= 1'b0;
			w_data_r       <= 32'h00000000;
			w_strb_r       <= 4'h0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp  <= `MSCFG_RESP_OKAY;
			step_div_r     <= `MSCFG_CTRL_RST;
			irq_mask_r     <= `MSCFG_IRQ_RST;
			irq_stat_r     <= `MSCFG_IRQ_RST;
		end else if (i_ce) begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= i_s_axi_wdata;
				w_strb_r <= i_s_axi_wstrb;
			end
			if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
			// hardware set wins over write-one clear
			irq_stat_r <= irq_stat_r | irq_set_nxt;
			if (wr_fire) begin
				aw_held_r      <= 1'b0;
				w_held_r       <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp  <= `MSCFG_RESP_OKAY;
				if (aw_addr_r == `MSCFG_ADDR_CTRL) begin
					if (w_strb_r[0]) step_div_r <= w_data_r[3:0];
				end else if (aw_addr_r == `MSCFG_ADDR_IRQ_STAT) begin
					if (w_strb_r[0]) irq_stat_r <= (irq_stat_r & ~w_data_r[`MSCFG_IRQ_W-1:0]) | irq_set_nxt;
				end else if (aw_addr_r == `MSCFG_ADDR_IRQ_MASK) begin
					if (w_strb_r[0]) irq_mask_r <= w_data_r[`MSCFG_IRQ_W-1:0];
				end else if (aw_addr_r == `MSCFG_ADDR_STATUS) begin
					o_s_axi_bresp <= `MSCFG_RESP_OKAY;
				end else begin
					o_s_axi_bresp <= `MSCFG_RESP_SLVERR;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	assign o_s_axi_arready = !o_s_axi_rvalid;
	assign rd_fire         = i_s_axi_arvalid && o_s_axi_arready;

	// read mux
	always @* begin
		rdata_nxt = 32'h00000000;
		rresp_nxt = `MSCFG_RESP_OKAY;
		if (i_s_axi_araddr == `MSCFG_ADDR_CTRL) begin
			rdata_nxt[3:0] = step_div_r;
		end else if (i_s_axi_araddr == `MSCFG_ADDR_STATUS) begin
			rdata_nxt[7:0]   = o_ref_tap;
			rdata_nxt[15:8]  = target_r;
			rdata_nxt[16]    = o_config_valid;
			rdata_nxt[17]    = o_family_second;
			rdata_nxt[18]    = o_sense_switch;
			rdata_nxt[19]    = o_table_eight_bit;
			rdata_nxt[20]    = o_code_transition_flag;
			rdata_nxt[21]    = power_ok_r;
			rdata_nxt[22]    = moving_r;
		end else if (i_s_axi_araddr == `MSCFG_ADDR_IRQ_STAT) begin
			rdata_nxt[`MSCFG_IRQ_W-1:0] = irq_stat_r;
		end else if (i_s_axi_araddr == `MSCFG_ADDR_IRQ_MASK) begin
			rdata_nxt[`MSCFG_IRQ_W-1:0] = irq_mask_r;
		end else begin
			rresp_nxt = `MSCFG_RESP_SLVERR;
		end
	end

	// one read answer at a time
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata  <= 32'h00000000;
			o_s_axi_rresp  <= `MSCFG_RESP_OKAY;
		end else if (i_ce) begin
			if (rd_fire) begin
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rdata  <= rdata_nxt;
				o_s_axi_rresp  <= rresp_nxt;
			end else if (o_s_axi_rvalid && i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // mscfg_top

// ===== verif/mscfg_board.sv
`timescale 1ns/1ps
// ----
// board straps and processor code pins
// ----
module mscfg_board (
	input  logic       i_clk_sys,
	input  logic       i_srst,
	input  logic [1:0] i_strap_req,
	input  logic       i_table_req,
	input  logic [7:0] i_code,
	input  logic [7:0] i_drive,
	output logic [1:0] o_strap_level,
	output logic       o_code_table_select,
	output logic [7:0] o_voltage_code_level,
	output logic [7:0] o_voltage_code_driven
);
	logic [2:0] keep_r;
	// table select grounded in second family
	wire  [2:0] want = {i_strap_req, i_table_req & ~i_strap_req[1]};
	// strap only follows the request while powered down
	always @(posedge i_clk_sys) if (i_srst) keep_r <= want;
	assign {o_strap_level, o_code_table_select} = i_srst ? want : keep_r;
	// open pins float to the inverse of the code; bit six grounded, bit seven freed in second family
	assign o_voltage_code_level = ~(i_code ^ i_drive) & (o_strap_level[1] ? 8'h3F : 8'hFF);
	assign o_voltage_code_driven = o_strap_level[1] ? {2'h1, i_drive[5:0]} : i_drive;
endmodule // mscfg_board

// ===== verif/mscfg_checker.sv
`timescale 1ns/1ps
// ----
// configuration checker
// ----
module mscfg_checker (
	input logic       i_clk_sys,
	input logic       i_srst,
	input logic [1:0] i_strap_level,
	input logic       i_code_table_select,
	input logic       i_softstart_done,
	input logic       i_output_in_limits,
	input logic       o_config_valid,
	input logic       o_family_second,
	input logic       o_sense_switch,
	input logic       o_table_eight_bit,
	input logic       o_setpoint_offset_en,
	input logic       o_softstart_program_en,
	input logic       o_ref_out_en,
	input logic [7:0] o_ref_tap,
	input logic       o_code_transition_flag,
	input logic       o_code_transition_flag_oe,
	input logic       o_softstart_done_or_power_ok_oe,
	input logic       o_irq
);
	logic [7:0] tap_q_r;
	logic [5:0] gap_r;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	// previous tap and cycles since its last move
	always @(posedge i_clk_sys) begin
		tap_q_r <= o_ref_tap;
		if (i_srst) gap_r <= 6'h3F;
		else if (o_ref_tap != tap_q_r) gap_r <= 6'h00;
		else if (gap_r != 6'h3F) gap_r <= gap_r + 6'h01;
	end
	a_strap_decode: assert property ($rose(o_config_valid) |->
		{o_family_second, o_sense_switch, o_table_eight_bit} == {i_strap_level, i_code_table_select})
		else $error("strap decode wrong");
	a_cfg_hold: assert property (o_config_valid && $past(o_config_valid) |->
		$stable({o_family_second, o_sense_switch, o_table_eight_bit})) else $error("configuration moved");
	a_offset_first: assert property (o_config_valid |-> o_setpoint_offset_en == !o_family_second)
		else $error("offset enable wrong");
	a_ref_pin: assert property (o_config_valid |-> o_ref_out_en == o_family_second &&
		o_softstart_program_en != o_family_second) else $error("soft-start pin role wrong");
	a_flag_dir: assert property (o_config_valid && $past(o_config_valid) |->
		o_code_transition_flag_oe == o_family_second)
		else $error("flag pin direction wrong");
	a_flag_tail: assert property (o_config_valid && o_family_second && gap_r < 6'h1E |->
		o_code_transition_flag) else $error("flag dropped early");
	a_tap_step: assert property (o_ref_tap != tap_q_r |->
		o_ref_tap - tap_q_r == 8'h01 || tap_q_r - o_ref_tap == 8'h01) else $error("tap jumped");
	a_status_first: assert property (o_config_valid && !o_family_second |=>
		o_softstart_done_or_power_ok_oe == !$past(i_softstart_done)) else $error("status pin wrong");
	a_status_good: assert property (o_config_valid && o_family_second |=>
		o_softstart_done_or_power_ok_oe == !($past(i_softstart_done) && $past(i_output_in_limits)))
		else $error("power good wrong");
	c_tail_end: cover property (o_family_second && $fell(o_code_transition_flag));
	c_released: cover property (o_config_valid && $fell(o_softstart_done_or_power_ok_oe));
	c_irq: cover property ($rose(o_irq));
endmodule // mscfg_checker
bind mscfg_top mscfg_checker i_mscfg_checker (.*);

// ===== verif/mscfg_tb_top.sv
`timescale 1ns/1ps
`include "mscfg_defines.vh"
// ----
// configuration bench
// ----
module mscfg_tb_top;
	logic i_clk_sys = 1'h0, i_srst = 1'h1, i_ce = 1'h1, i_softstart_done = 1'h0, i_output_in_limits = 1'h0;
	logic i_table_req = 1'h0, i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
	logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
	logic [1:0] i_strap_req = 2'h0, resp;
	logic [3:0] i_s_axi_awaddr = 4'h0, i_s_axi_araddr = 4'h0, i_s_axi_wstrb = 4'hF;
	logic [7:0] i_code = 8'h00, i_drive = 8'h00, e;
	logic [31:0] i_s_axi_wdata = 32'h0, q;
	wire [1:0] i_strap_level, o_s_axi_bresp, o_s_axi_rresp;
	wire [7:0] i_voltage_code_level, i_voltage_code_driven, o_ref_tap;
	wire [31:0] o_s_axi_rdata;
	wire i_code_table_select, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	wire o_config_valid, o_family_second, o_sense_switch, o_table_eight_bit, o_setpoint_offset_en, o_irq;
	wire o_softstart_program_en, o_ref_out_en, o_code_transition_flag, o_code_transition_flag_oe;
	wire o_softstart_done_or_power_ok, o_softstart_done_or_power_ok_oe;
	int bad_count = 0, compares = 0, n;
	mscfg_top i_mscfg_top (.*);
	mscfg_board i_mscfg_board (.*, .o_strap_level(i_strap_level), .o_code_table_select(i_code_table_select),
		.o_voltage_code_level(i_voltage_code_level), .o_voltage_code_driven(i_voltage_code_driven));
	// 50 MHz clock
	always #10 i_clk_sys = ~i_clk_sys;
	// compare and count
	task chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// one clock with a bounded count
	task tick;
		@(posedge i_clk_sys);
		n++;
	endtask
	// one axi4-lite transfer, write when wr is high
	task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
		logic f;
		@(posedge i_clk_sys);
		f = 1'h0;
		n = 0;
		i_s_axi_awaddr <= a;
		i_s_axi_araddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= wr;
		i_s_axi_wvalid <= wr;
		i_s_axi_bready <= wr;
		i_s_axi_arvalid <= ~wr;
		i_s_axi_rready <= ~wr;
		while (!f && n < 200) begin
			tick();
			if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
			if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
			if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
			f = wr ? o_s_axi_bvalid : o_s_axi_rvalid;
		end
		i_s_axi_bready <= 1'h0;
		i_s_axi_rready <= 1'h0;
		q = o_s_axi_rdata;
		resp = wr ? o_s_axi_bresp : o_s_axi_rresp;
		if (!f) bad_count++;
	endtask
	// verdict and end of run
	task results;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#400000;
		bad_count++;
		results();
	end
	// every strap setting from power-up, then registers
	initial begin
		for (int s = 0; s < 4; s++) begin
			@(posedge i_clk_sys);
			i_srst <= 1'h1;
			i_strap_req <= s[1:0];
			i_table_req <= ~s[0];
			i_softstart_done <= 1'h0;
			i_output_in_limits <= 1'h0;
			i_code <= 8'hA6;
			i_drive <= 8'hF0;
			repeat (10) @(posedge i_clk_sys);
			i_srst <= 1'h0;
			n = 0;
			while (o_config_valid !== 1'h1 && n < 20) tick();
			// pin direction follows the capture by one edge
			tick();
			chk({o_family_second, o_sense_switch}, s[1:0]);
			chk(o_table_eight_bit, !s[0] && !s[1]);
			chk(o_setpoint_offset_en, !s[1]);
			chk({o_softstart_program_en, o_ref_out_en}, {!s[1], s[1]});
			chk(o_code_transition_flag_oe, s[1]);
			chk(o_softstart_done_or_power_ok_oe, 1);
			e = s[1] ? (i_code & i_drive & 8'h3F) : ((i_code & i_drive) | ~i_drive);
			n = 0;
			while (o_ref_tap !== e && n < 600) tick();
			chk(o_ref_tap, e);
			n = 0;
			while (o_code_transition_flag === 1'h1 && n < 99) tick();
			if (s[1]) chk(n > 27 && n < 41, 1);
			i_softstart_done <= 1'h1;
			repeat (3) @(posedge i_clk_sys);
			chk(o_softstart_done_or_power_ok_oe, s[1]);
			i_output_in_limits <= 1'h1;
			repeat (3) @(posedge i_clk_sys);
			chk(o_softstart_done_or_power_ok_oe, 0);
			$display("test strap %0d done", s);
		end
		acc(1'h0, `MSCFG_ADDR_STATUS, 32'h0);
		chk(q[22:0], 23'h272020);
		acc(1'h0, `MSCFG_ADDR_IRQ_STAT, 32'h0);
		chk({o_irq, q[2:0]}, 4'h3);
		acc(1'h1, `MSCFG_ADDR_IRQ_MASK, 32'h3);
		chk(o_irq, 1);
		acc(1'h1, `MSCFG_ADDR_IRQ_STAT, 32'h1);
		acc(1'h0, `MSCFG_ADDR_IRQ_STAT, 32'h0);
		chk({o_irq, q[2:0]}, 4'hA);
		acc(1'h1, `MSCFG_ADDR_IRQ_STAT, 32'h2);
		chk(o_irq, 0);
		acc(1'h1, `MSCFG_ADDR_CTRL, 32'h3);
		chk(resp, `MSCFG_RESP_OKAY);
		acc(1'h0, `MSCFG_ADDR_CTRL, 32'h0);
		chk(q[3:0], 4'h3);
		// runtime code change, first frozen by the clock enable, then walked with divider 3
		i_ce <= 1'h0;
		i_code <= 8'h22;
		i_drive <= 8'h3F;
		repeat (20) tick();
		chk(o_ref_tap, 8'h20);
		i_ce <= 1'h1;
		n = 0;
		while (o_ref_tap !== 8'h22 && n < 100) tick();
		chk({o_ref_tap, o_code_transition_flag}, {8'h22, 1'h1});
		chk(o_softstart_done_or_power_ok, 0);
		$display("test dynamic code done");
		acc(1'h0, 4'h2, 32'h0);
		chk(resp, `MSCFG_RESP_SLVERR);
		chk(q, 32'h0);
		$display("test registers done");
		results();
	end
endmodule // mscfg_tb_top
